// file: core/hsm_homing_seq.sv
// Purpose: homing sequencer using the home switch as slow-down and home point
// Assumes: control word and method code come from logic on clk_sys
// Notes: speed and direction go to the motion controller as plain levels
`timescale 1ns/1ps
`default_nettype none

module hsm_homing_seq
    import hsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [15:0] control_word,
    input wire logic [7:0] method_code,
    input wire logic home_switch_input,
    input wire logic pos_limit_in,
    input wire logic neg_limit_in,
    output logic dir_positive_ff,
    output logic speed_high_ff,
    output logic motion_run_ff,
    output logic homing_done_ff,
    output logic code_error_ff
);

    logic [HSM_NUM_INPUTS-1:0] sw_level;
    logic [HSM_NUM_INPUTS-1:0] sw_rise;
    logic [HSM_NUM_INPUTS-1:0] sw_fall;

    hsm_state_t state_ff;
    hsm_state_t nxt_state;
    logic [HSM_CFG_W-1:0] cfg_ff;
    logic [HSM_CFG_W-1:0] nxt_cfg;
    logic [15:0] cw_prev_ff;
    logic [7:0] code_prev_ff;
    logic rev_done_ff;
    logic nxt_rev_done;
    logic nxt_dir;
    logic nxt_speed;
    logic nxt_run;
    logic nxt_done;
    logic nxt_error;

    // switch pins cross into clk_sys here
    hsm_sync_edge u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .pin_in({neg_limit_in, pos_limit_in, home_switch_input}),
        .level(sw_level),
        .rise(sw_rise),
        .fall(sw_fall)
    );

    // decode of start, method and switch conditions
    wire home_lvl = sw_level[HSM_IN_HOME];
    wire home_rise = sw_rise[HSM_IN_HOME];
    wire home_fall = sw_fall[HSM_IN_HOME];
    wire start_req = (cw_prev_ff == HSM_CW_READY) && (control_word == HSM_CW_START);
    wire code_ok = (method_code >= HSM_CODE_FIRST) && (method_code <= HSM_CODE_LAST);
    wire [7:0] code_index = method_code - HSM_CODE_FIRST;
    wire [HSM_CFG_W-1:0] sel_cfg = code_ok ? HSM_METHOD_TBL[code_index[3:0]] : '0;
    wire busy = (state_ff == HSM_SEARCH) || (state_ff == HSM_APPROACH) ||
                (state_ff == HSM_FINAL);
    // dropping the start bit mid-run abandons the search, approach or final phase
    wire abort_req = busy && !control_word[HSM_CW_START_BIT];
    wire code_changed = method_code != code_prev_ff;
    // limit in the current travel direction; only high-speed search reacts
    wire limit_ahead = dir_positive_ff ? sw_level[HSM_IN_PLIM] : sw_level[HSM_IN_NLIM];
    wire limit_reverse = speed_high_ff && limit_ahead && !rev_done_ff;

    // sequencing of search, approach and final phases
    always_comb begin
        nxt_state = state_ff;
        nxt_cfg = cfg_ff;
        nxt_rev_done = rev_done_ff;
        nxt_dir = dir_positive_ff;
        nxt_speed = speed_high_ff;
        nxt_run = motion_run_ff;
        nxt_done = homing_done_ff;
        nxt_error = code_error_ff;
        case (state_ff)
            HSM_IDLE, HSM_DONE: begin
                nxt_run = 1'b0;
                if (start_req && !code_ok) begin
                    nxt_error = 1'b1;
                end else if (start_req) begin
                    nxt_error = 1'b0;
                    nxt_done = 1'b0;
                    nxt_run = 1'b1;
                    nxt_rev_done = 1'b0;
                    nxt_cfg = sel_cfg;
                    // path chosen from the sampled switch level
                    if (home_lvl) begin
                        // already on the switch
                        nxt_state = HSM_APPROACH;
                        nxt_dir = sel_cfg[HSM_CFG_D_DIR];
                        nxt_speed = sel_cfg[HSM_CFG_D_HI];
                    end else begin
                        // off the switch
                        nxt_state = HSM_SEARCH;
                        nxt_dir = sel_cfg[HSM_CFG_A_DIR];
                        nxt_speed = sel_cfg[HSM_CFG_A_HI];
                    end
                end else if (code_changed) begin
                    // a new code wipes the last result
                    nxt_state = HSM_IDLE;
                    nxt_done = 1'b0;
                    nxt_error = 1'b0;
                end
            end
            HSM_SEARCH: begin
                if (abort_req) begin
                    nxt_state = HSM_IDLE;
                    nxt_run = 1'b0;
                end else if (home_rise && !speed_high_ff) begin
                    // low-speed search homes on the rising edge
                    nxt_state = HSM_DONE;
                    nxt_run = 1'b0;
                    nxt_done = 1'b1;
                end else if (home_rise) begin
                    // decelerate, direction fixed per method
                    // same direction after a limit reversal
                    nxt_state = HSM_APPROACH;
                    nxt_speed = 1'b0;
                    nxt_dir = cfg_ff[HSM_CFG_B_DIR];
                end else if (limit_reverse) begin
                    // bounce off the limit at high speed
                    nxt_dir = !dir_positive_ff;
                    nxt_rev_done = 1'b1;
                end
            end
            HSM_APPROACH: begin
                if (abort_req) begin
                    nxt_state = HSM_IDLE;
                    nxt_run = 1'b0;
                end else if (home_fall && cfg_ff[HSM_CFG_STOP_F]) begin
                    // home on the falling edge
                    nxt_state = HSM_DONE;
                    nxt_run = 1'b0;
                    nxt_done = 1'b1;
                end else if (home_fall) begin
                    // reverse at low speed
                    nxt_state = HSM_FINAL;
                    nxt_speed = 1'b0;
                    nxt_dir = !dir_positive_ff;
                end
            end
            HSM_FINAL: begin
                if (abort_req) begin
                    nxt_state = HSM_IDLE;
                    nxt_run = 1'b0;
                end else if (home_rise) begin
                    // final rising edge is home
                    nxt_state = HSM_DONE;
                    nxt_run = 1'b0;
                    nxt_done = 1'b1;
                end
            end
            default: begin
                nxt_state = HSM_IDLE;
                nxt_run = 1'b0;
            end
        endcase
    end

    // sequencer state and outputs, frozen while clk_en is low
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_ff <= HSM_IDLE;
            cfg_ff <= '0;
            rev_done_ff <= 1'b0;
            dir_positive_ff <= 1'b0;
            speed_high_ff <= 1'b0;
            motion_run_ff <= 1'b0;
            homing_done_ff <= 1'b0;
            code_error_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cfg_ff <= nxt_cfg;
            rev_done_ff <= nxt_rev_done;
            dir_positive_ff <= nxt_dir;
            speed_high_ff <= nxt_speed;
            motion_run_ff <= nxt_run;
            homing_done_ff <= nxt_done;
            code_error_ff <= nxt_error;
        end
    end

    // history of the control word and code for change detection
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cw_prev_ff <= 16'h0000;
            code_prev_ff <= 8'h00;
        end else if (clk_en) begin
            cw_prev_ff <= control_word;
            code_prev_ff <= method_code;
        end
    end

    // checks on the sequencer
    a_path_off_switch: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !busy && start_req && code_ok && !home_lvl
        |=> state_ff == HSM_SEARCH && motion_run_ff &&
            dir_positive_ff == $past(sel_cfg[HSM_CFG_A_DIR]) &&
            speed_high_ff == $past(sel_cfg[HSM_CFG_A_HI]))
        else $error("search start does not follow the method row");

    a_path_on_switch: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !busy && start_req && code_ok && home_lvl
        |=> state_ff == HSM_APPROACH &&
            dir_positive_ff == $past(sel_cfg[HSM_CFG_D_DIR]) &&
            speed_high_ff == $past(sel_cfg[HSM_CFG_D_HI]))
        else $error("start on switch does not follow the method row");

    a_low_search_stop: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !abort_req && state_ff == HSM_SEARCH && home_rise && !speed_high_ff
        |=> state_ff == HSM_DONE && homing_done_ff && !motion_run_ff)
        else $error("low speed search did not stop on rising edge");

    a_search_decel: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !abort_req && state_ff == HSM_SEARCH && home_rise && speed_high_ff
        |=> state_ff == HSM_APPROACH && !speed_high_ff &&
            dir_positive_ff == cfg_ff[HSM_CFG_B_DIR])
        else $error("high speed search did not slow on rising edge");

    a_fall_reverse: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !abort_req && state_ff == HSM_APPROACH && home_fall &&
        !cfg_ff[HSM_CFG_STOP_F]
        |=> state_ff == HSM_FINAL && !speed_high_ff &&
            dir_positive_ff != $past(dir_positive_ff))
        else $error("falling edge did not reverse at low speed");

    a_limit_bounce: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !abort_req && state_ff == HSM_SEARCH && !home_rise && limit_reverse
        |=> speed_high_ff && dir_positive_ff != $past(dir_positive_ff) && rev_done_ff)
        else $error("limit did not reverse the high speed search");

    a_final_stop: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !abort_req && state_ff == HSM_FINAL && home_rise
        |=> state_ff == HSM_DONE ##1 !motion_run_ff)
        else $error("final rising edge did not stop the motor");

    a_edge_levels: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (home_rise |-> home_lvl) and (home_fall |-> !home_lvl))
        else $error("edge flag disagrees with sampled level");

    a_code_clears: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && state_ff == HSM_DONE && code_changed && !start_req
        |=> state_ff == HSM_IDLE && !homing_done_ff)
        else $error("new method code did not clear the result");

    a_idle_still: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (state_ff == HSM_IDLE || state_ff == HSM_DONE) |-> !motion_run_ff)
        else $error("motor runs while idle");

    // refusals and the stop on falling edge; a start while busy must not disturb the run
    a_abort_idle: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && abort_req
        |=> state_ff == HSM_IDLE && !motion_run_ff && !homing_done_ff)
        else $error("dropped start bit did not stop the run");

    a_bad_code_flag: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !busy && start_req && !code_ok
        |=> code_error_ff && !motion_run_ff && !busy)
        else $error("bad method code was not refused");

    a_fall_home: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !abort_req && state_ff == HSM_APPROACH && home_fall &&
        cfg_ff[HSM_CFG_STOP_F]
        |=> state_ff == HSM_DONE && homing_done_ff && !motion_run_ff)
        else $error("falling edge did not stop the motor");

    a_limit_once: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && state_ff == HSM_SEARCH && rev_done_ff && !home_rise && !abort_req
        |=> state_ff == HSM_SEARCH && dir_positive_ff == $past(dir_positive_ff))
        else $error("second limit hit changed the search");

    a_busy_no_restart: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && busy && !abort_req && !home_rise && !home_fall && !limit_reverse
        |=> state_ff == $past(state_ff) && motion_run_ff)
        else $error("sequencer moved without a switch event");

endmodule
`default_nettype wire

// file: core/hsm_pkg.sv
// Purpose: constants and types for the home switch homing sequencer
// Assumes: method codes arrive as an 8-bit value from the object layer
// Notes: one table row per method, indexed by code minus the first code
package hsm_pkg;

    // method code range handled by this block
    localparam logic [7:0] HSM_CODE_FIRST = 8'h14;
    localparam logic [7:0] HSM_CODE_LAST = 8'h1C;
    localparam int HSM_NUM_METHODS = 9;

    // control word values that arm and fire a homing run
    localparam logic [15:0] HSM_CW_READY = 16'h000F;
    localparam logic [15:0] HSM_CW_START = 16'h001F;
    localparam int HSM_CW_START_BIT = 4;

    // synchronised input lanes
    localparam int HSM_NUM_INPUTS = 3;
    localparam int HSM_IN_HOME = 0;
    localparam int HSM_IN_PLIM = 1;
    localparam int HSM_IN_NLIM = 2;

    // method descriptor fields; direction bit high means positive
    localparam int HSM_CFG_W = 6;
    localparam int HSM_CFG_A_DIR = 5;   // search direction, switch inactive at start
    localparam int HSM_CFG_A_HI = 4;    // search speed high, switch inactive at start
    localparam int HSM_CFG_B_DIR = 3;   // low-speed direction after search rising edge
    localparam int HSM_CFG_STOP_F = 2;  // stop on falling edge instead of final rising edge
    localparam int HSM_CFG_D_DIR = 1;   // direction, switch active at start
    localparam int HSM_CFG_D_HI = 0;    // speed high, switch active at start

    // one row per method code, first code at index zero
    localparam logic [HSM_CFG_W-1:0] HSM_METHOD_TBL [0:HSM_NUM_METHODS-1] = '{
        6'h21,  // first code: pos low to rising; active: neg high then pos low
        6'h1E,  // neg high, rising to pos low, stop falling; active: pos low
        6'h03,  // neg low to rising; active: pos high then neg low
        6'h34,  // pos high, rising to neg low, stop falling; active: neg low
        6'h30,  // pos high, neg low, then pos low to rising; active: neg low
        6'h3A,  // pos high, pos low, then neg low to rising; active: pos low
        6'h3E,  // pos high, pos low, stop falling; active: pos low
        6'h1E,  // neg high, pos low, stop falling; active: pos low
        6'h1A   // neg high, pos low, then neg low to rising; active: pos low
    };

    typedef enum logic [2:0] {
        HSM_IDLE,
        HSM_SEARCH,
        HSM_APPROACH,
        HSM_FINAL,
        HSM_DONE
    } hsm_state_t;

endpackage

// file: core/hsm_sync_edge.sv
// Purpose: two-stage synchroniser and edge detector per switch input
// Assumes: switch pins are asynchronous to clk_sys
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module hsm_sync_edge
    import hsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [HSM_NUM_INPUTS-1:0] pin_in,
    output logic [HSM_NUM_INPUTS-1:0] level,
    output logic [HSM_NUM_INPUTS-1:0] rise,
    output logic [HSM_NUM_INPUTS-1:0] fall
);

    genvar gi;
    generate
        for (gi = 0; gi < HSM_NUM_INPUTS; gi++) begin : g_lane
            logic meta_ff;
            logic sync_ff;
            logic prev_ff;

            // two flops then one history flop for edge compare
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    prev_ff <= 1'b0;
                end else if (clk_en) begin
                    meta_ff <= pin_in[gi];
                    sync_ff <= meta_ff;
                    prev_ff <= sync_ff;
                end
            end

            // edges from consecutive sampled levels
            assign level[gi] = sync_ff;
            assign rise[gi] = sync_ff & ~prev_ff;
            assign fall[gi] = ~sync_ff & prev_ff;
        end
    endgenerate

endmodule
`default_nettype wire

// file: verification/hsm_axis_model.sv
// Purpose: behavioural axis with home zone and two travel limits
// Assumes: switch levels follow position, active high, no bounce
// Notes: motion only advances position on enabled cycles, so edge latency in the
//        sequencer never turns into unbounded overshoot
`timescale 1ns/1ps
`default_nettype none
module hsm_axis_model #(
    parameter int HOME_LO = 0,
    parameter int HOME_HI = 40,
    parameter int PLIM_AT = 200,
    parameter int NLIM_AT = -200,
    parameter int FAST_STEP = 4,
    parameter int SLOW_STEP = 1
) (
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic load,
    input wire logic signed [15:0] load_pos,
    input wire logic run,
    input wire logic dir_positive,
    input wire logic speed_high,
    output logic home_sw,
    output logic pos_limit,
    output logic neg_limit
);
    logic signed [15:0] pos_ff = 16'sh0064;
    logic signed [15:0] step;

    // step size stands in for the controller's two speed profiles
    assign step = speed_high ? 16'(FAST_STEP) : 16'(SLOW_STEP);

    // position integrates the commanded motion, or jumps on a preset
    always @(posedge clk_sys) begin
        if (load) begin
            pos_ff <= load_pos;
        end else if (clk_en && run) begin
            if (dir_positive) begin
                pos_ff <= pos_ff + step;
            end else begin
                pos_ff <= pos_ff - step;
            end
        end
    end

    // switches are plain position windows; limits stay on past their mark
    assign home_sw = (pos_ff >= HOME_LO) && (pos_ff <= HOME_HI);
    assign pos_limit = pos_ff >= PLIM_AT;
    assign neg_limit = pos_ff <= NLIM_AT;
endmodule
`default_nettype wire

// file: verification/home_switch_homing_sequencer_bench.sv
// Purpose: self-checking bench for the homing sequencer
// Assumes: axis model moves 4 or 1 units per enabled cycle
// Notes: outputs are compared only when their masked value changes,
//        so direction and speed while stopped are left to the design
`timescale 1ns/1ps
`default_nettype none
module home_switch_homing_sequencer_bench;
    import hsm_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [15:0] control_word = 16'h0000;
    logic [7:0] method_code = 8'h14;
    logic home_sw, plim, nlim, dir_pos, spd_hi, run, done, err;
    logic load = 1'b0;
    logic signed [15:0] load_pos = 16'sh0000;
    logic [4:0] exp_q[$];
    logic [4:0] seen_prev = 5'h00;
    logic [4:0] seen;
    logic watch_on = 1'b0;
    logic en_random = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;
    int seed = 32'h935c;
    int i, pass;
    string off_path[9] = '{"p", "Rp", "n", "Fn", "Fnp", "Fpn", "Fp", "Rp", "Rpn"};
    string on_path[9] = '{"Rp", "p", "Fn", "n", "np", "pn", "p", "p", "pn"};

    always #25 clk_sys = ~clk_sys;

    hsm_homing_seq uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .control_word(control_word), .method_code(method_code),
        .home_switch_input(home_sw), .pos_limit_in(plim), .neg_limit_in(nlim),
        .dir_positive_ff(dir_pos), .speed_high_ff(spd_hi), .motion_run_ff(run),
        .homing_done_ff(done), .code_error_ff(err)
    );

    hsm_axis_model axis (
        .clk_sys(clk_sys), .clk_en(clk_en), .load(load), .load_pos(load_pos),
        .run(run), .dir_positive(dir_pos), .speed_high(spd_hi),
        .home_sw(home_sw), .pos_limit(plim), .neg_limit(nlim)
    );

    // direction and speed only matter while the motor is commanded to move
    assign seen = {err, done, run, run & dir_pos, run & spd_hi};

    task automatic check(input logic [4:0] got, input logic [4:0] want);
        cmp_count++;
        if (got !== want) begin
            n_fail++;
            $display("BAD t=%0t seen=%h want=%h", $time, got, want);
        end
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // F fast positive, p slow positive, R fast negative, n slow negative
    function automatic logic [4:0] step_vec(input byte c);
        case (c)
            "F": step_vec = 5'h07;
            "p": step_vec = 5'h06;
            "R": step_vec = 5'h05;
            "n": step_vec = 5'h04;
            default: step_vec = 5'h1F;
        endcase
    endfunction

    // sampled on the falling edge, well clear of the register updates
    always @(negedge clk_sys) begin
        if (watch_on && seen !== seen_prev) begin
            if (exp_q.size() == 0) begin
                check(seen, 5'h1F);
            end else begin
                check(seen, exp_q.pop_front());
            end
            seen_prev = seen;
        end
    end

    // random enable stretches every latency without changing the path
    always @(posedge clk_sys) begin
        clk_en <= en_random ? (($random(seed) & 3) != 0) : 1'b1;
    end

    // cut: 0 full run, 1 abort by control word, 2 abort by reset
    task automatic homing_run(input logic [7:0] code, input int start_pos,
                              input string path, input int cut);
        int k;
        if (code !== method_code && seen_prev[4:3] !== 2'b00) begin
            exp_q.push_back(5'h00);
        end
        method_code <= code;
        load <= 1'b1;
        load_pos <= 16'(start_pos + ($random(seed) & 7));
        @(posedge clk_sys);
        load <= 1'b0;
        control_word <= HSM_CW_READY;
        // room for enabled edges through the synchroniser under random enable
        tick(12);
        if (path.len() == 0) begin
            exp_q.push_back(5'h10);
        end else if (cut != 0) begin
            exp_q.push_back(step_vec(path[0]));
        end else begin
            for (int j = 0; j < path.len(); j++) begin
                exp_q.push_back(step_vec(path[j]));
            end
            exp_q.push_back(5'h08);
        end
        control_word <= HSM_CW_START;
        if (cut != 0) begin
            tick(30);
            exp_q.push_back(5'h00);
            if (cut == 1) begin
                control_word <= HSM_CW_READY;
            end else begin
                reset_n <= 1'b0;
                tick(2);
                reset_n <= 1'b1;
            end
            tick(6);
        end else begin
            tick(8);
            k = 0;
            while (done !== 1'b1 && err !== 1'b1 && k < 6000) begin
                @(negedge clk_sys);
                k++;
            end
            if (k == 6000) begin
                n_fail++;
                report_and_stop();
            end
        end
        tick(2);
        check(5'(exp_q.size()), 5'h00);
    endtask

    // main sequence: every code from both switch levels, then limits and faults
    initial begin
        tick(12);
        reset_n <= 1'b1;
        tick(2);
        watch_on = 1'b1;
        for (pass = 0; pass < 2; pass++) begin
            en_random = (pass == 1);
            for (i = 0; i < 9; i++) begin
                homing_run(8'h14 + 8'(i), (off_path[i][0] inside {"F", "p"}) ? -100 : 100,
                           off_path[i], 0);
                homing_run(8'h14 + 8'(i), 20, on_path[i], 0);
            end
        end
        homing_run(8'h18, 100, "FRnp", 0);
        homing_run(8'h19, 100, "FRpn", 0);
        homing_run(8'h1A, 100, "FRp", 0);
        homing_run(8'h1C, -100, "RFpn", 0);
        en_random = 1'b0;
        homing_run(8'h13, 20, "", 0);
        homing_run(8'h1D, 20, "", 0);
        homing_run(8'h14, -100, "p", 1);
        homing_run(8'h16, 100, "n", 2);
        homing_run(8'h17, 20, "n", 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
